// >>> hdl/pkh_pkg.sv
// Constants, register map and state types of the packet handler configuration block
package pkh_pkg;

    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [9:0] IDX_MARK2   = 10'h037;
    localparam logic [9:0] IDX_MARK1   = 10'h038;
    localparam logic [9:0] IDX_MARK0   = 10'h039;
    localparam logic [9:0] IDX_HDR3    = 10'h03a;
    localparam logic [9:0] IDX_HDR2    = 10'h03b;
    localparam logic [9:0] IDX_HDR1    = 10'h03c;
    localparam logic [9:0] IDX_HDR0    = 10'h03d;
    localparam logic [9:0] IDX_LEN     = 10'h03e;
    localparam logic [9:0] IDX_EXPECT3 = 10'h03f;
    localparam logic [9:0] IDX_CTRL    = 10'h050;
    localparam logic [9:0] IDX_STAT    = 10'h051;

    localparam int CFG_BYTES = 9;

    // ==========================================================
    // Reset values, slot 0 (marker byte 2) in the low byte
    localparam logic [71:0] CFG_RST = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                       8'h00, 8'h00, 8'h00, 8'hd4};
    localparam logic [7:0]  CTRL_RST = 8'h14;

    // ==========================================================
    // Control and status fields
    localparam int CTRL_HDLEN_LSB   = 0;
    localparam int CTRL_FIX_BIT     = 3;
    localparam int CTRL_SYNCLEN_LSB = 4;
    localparam int CTRL_CHECK_BIT   = 6;
    localparam int CTRL_GO_BIT      = 7;
    localparam int STAT_BUSY_BIT    = 0;
    localparam int STAT_ACCEPT_BIT  = 1;
    localparam int STAT_REJECT_BIT  = 2;
    localparam int STAT_LEN_LSB     = 8;

    localparam logic [2:0] HDLEN_MAX   = 3'h4;
    localparam logic [7:0] PREAMBLE_PATTERN = 8'haa;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Sequencer states
    typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_SYNC, TX_HDR, TX_LEN, TX_PAY} pkh_tx_e;
    typedef enum logic [2:0] {RX_IDLE, RX_HDR, RX_LEN, RX_PAY, RX_DONE} pkh_rx_e;

endpackage

// >>> hdl/pkh_tx_seq.sv
// Outbound frame sequencer: preamble, marker, header, length, payload
`timescale 1ns/1ns
`default_nettype none
module pkh_tx_seq #(
    parameter int PREAMBLE_BYTES = 4
) (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        start,
    input  wire logic [31:0] sync_word,
    input  wire logic [31:0] header_word,
    input  wire logic [2:0]  hdr_count,
    input  wire logic        fixed_len,
    input  wire logic [1:0]  sync_count,
    input  wire logic [7:0]  pay_len,
    input  wire logic [7:0]  pay_data,
    input  wire logic        pay_valid,
    output logic             pay_ready,
    output logic [7:0]       out_data,
    output logic             out_valid,
    input  wire logic        out_ready,
    output logic             busy
);
    pkh_pkg::pkh_tx_e state_q;
    logic [7:0]       cnt_q;
    logic [7:0]       data_q;
    logic             valid_q;

    // Skips sections that carry no bytes
    function automatic pkh_pkg::pkh_tx_e skip(input pkh_pkg::pkh_tx_e s);
        pkh_pkg::pkh_tx_e r;
        r = s;
        if (r == pkh_pkg::TX_HDR && hdr_count == 3'h0) r = pkh_pkg::TX_LEN;
        if (r == pkh_pkg::TX_LEN && fixed_len) r = pkh_pkg::TX_PAY;
        if (r == pkh_pkg::TX_PAY && pay_len == 8'h00) r = pkh_pkg::TX_IDLE;
        return r;
    endfunction

    wire [1:0] sel      = 2'h3 - cnt_q[1:0];
    wire [7:0] sec_len  = (state_q == pkh_pkg::TX_PRE)  ? 8'(PREAMBLE_BYTES) :
                          (state_q == pkh_pkg::TX_SYNC) ? {6'h0, sync_count} + 8'h1 :
                          (state_q == pkh_pkg::TX_HDR)  ? {5'h0, hdr_count} :
                          (state_q == pkh_pkg::TX_LEN)  ? 8'h1 : pay_len;
    wire [7:0] byte_d   = (state_q == pkh_pkg::TX_PRE)  ? pkh_pkg::PREAMBLE_PATTERN :
                          (state_q == pkh_pkg::TX_SYNC) ? sync_word[{sel, 3'h0} +: 8] :
                          (state_q == pkh_pkg::TX_HDR)  ? header_word[{sel, 3'h0} +: 8] :
                          (state_q == pkh_pkg::TX_LEN)  ? pay_len : pay_data;
    wire       have     = state_q != pkh_pkg::TX_IDLE && (state_q != pkh_pkg::TX_PAY || pay_valid);
    wire       slot     = !valid_q || out_ready;
    wire       advance  = have && slot;
    wire       sec_end  = cnt_q == sec_len - 8'h1;
    // Section order fixes the frame layout
    wire pkh_pkg::pkh_tx_e after = (state_q == pkh_pkg::TX_PRE)  ? pkh_pkg::TX_SYNC :
                                   (state_q == pkh_pkg::TX_SYNC) ? skip(pkh_pkg::TX_HDR) :
                                   (state_q == pkh_pkg::TX_HDR)  ? skip(pkh_pkg::TX_LEN) :
                                   (state_q == pkh_pkg::TX_LEN)  ? skip(pkh_pkg::TX_PAY) :
                                   pkh_pkg::TX_IDLE;

    assign pay_ready = advance && state_q == pkh_pkg::TX_PAY;
    assign out_data  = data_q;
    assign out_valid = valid_q;
    assign busy      = state_q != pkh_pkg::TX_IDLE || valid_q;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_q <= pkh_pkg::TX_IDLE;
            cnt_q   <= 8'h00;
        end else if (state_q == pkh_pkg::TX_IDLE) begin
            cnt_q <= 8'h00;
            if (start) state_q <= pkh_pkg::TX_PRE;
        end else if (advance) begin
            cnt_q   <= sec_end ? 8'h00 : cnt_q + 8'h1;
            if (sec_end) state_q <= after;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            valid_q <= 1'b0;
            data_q  <= 8'h00;
        end else if (slot) begin
            valid_q <= have;
            if (have) data_q <= byte_d;
        end
    end

    // ==========================================================
    // Checks
    sync_first_a: assert property (@(posedge mclk) disable iff (!rstn)
        state_q == pkh_pkg::TX_SYNC && cnt_q == 8'h0 && advance |=> out_data == $past(sync_word[31:24]))
        else $error("marker byte 3 not sent first");
    hdr_span_a: assert property (@(posedge mclk) disable iff (!rstn)
        state_q == pkh_pkg::TX_HDR |-> hdr_count != 3'h0 && cnt_q < {5'h0, hdr_count})
        else $error("header byte count exceeded");
    sync_span_a: assert property (@(posedge mclk) disable iff (!rstn)
        state_q == pkh_pkg::TX_SYNC |-> cnt_q <= {6'h0, sync_count})
        else $error("marker byte count exceeded");
    zero_pay_a: assert property (@(posedge mclk) disable iff (!rstn)
        pay_len == 8'h00 |-> !pay_ready)
        else $error("payload taken with zero length");
    frame_order_a: assert property (@(posedge mclk) disable iff (!rstn)
        state_q == pkh_pkg::TX_PAY |=> state_q inside {pkh_pkg::TX_PAY, pkh_pkg::TX_IDLE})
        else $error("section after payload");
endmodule
`default_nettype wire

// >>> hdl/pkh_top.sv
// Packet handler configuration registers with AXI4-Lite slave, frame builder and header checker
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module pkh_top #(
    parameter int PREAMBLE_BYTES = 4
) (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  marker_byte3,
    input  wire logic [23:0] expected_header_low,
    input  wire logic [3:0]  header_check_mask,
    input  wire logic [7:0]  pay_data,
    input  wire logic        pay_valid,
    output logic             pay_ready,
    output logic [7:0]       tx_data,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic             tx_busy,
    input  wire logic        rx_start,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_valid,
    output logic             rx_accept,
    output logic             rx_reject
);
    // ==========================================================
    // Register bus
    localparam int CFG_N = pkh_pkg::CFG_BYTES;

    logic        aw_q;
    logic        w_q;
    logic [9:0]  wr_idx_q;
    logic [7:0]  wr_byte_q;
    logic        wr_lane_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic [7:0]  cfg_q [CFG_N];
    logic [7:0]  ctrl_q;
    logic        go_q;

    function automatic logic mapped(input logic [9:0] idx);
        return (idx >= pkh_pkg::IDX_MARK2 && idx <= pkh_pkg::IDX_EXPECT3) ||
               idx == pkh_pkg::IDX_CTRL || idx == pkh_pkg::IDX_STAT;
    endfunction

    wire        wr_go    = aw_q && w_q && !bvalid_q;
    wire        wr_en    = wr_go && wr_lane_q;
    wire [9:0]  rd_idx   = s_axi_araddr[11:2];
    wire        rd_go    = s_axi_arvalid && !rvalid_q;
    wire [9:0]  rd_slot  = rd_idx - pkh_pkg::IDX_MARK2;
    wire        rd_cfg   = rd_idx >= pkh_pkg::IDX_MARK2 && rd_idx <= pkh_pkg::IDX_EXPECT3;

    assign s_axi_awready = !aw_q;
    assign s_axi_wready  = !w_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            aw_q      <= 1'b0;
            w_q       <= 1'b0;
            wr_idx_q  <= 10'h000;
            wr_byte_q <= 8'h00;
            wr_lane_q <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= pkh_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_q) begin
                aw_q     <= 1'b1;
                wr_idx_q <= s_axi_awaddr[11:2];
            end
            if (s_axi_wvalid && !w_q) begin
                w_q       <= 1'b1;
                wr_byte_q <= s_axi_wdata[7:0];
                wr_lane_q <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_q     <= 1'b0;
                w_q      <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= mapped(wr_idx_q) ? pkh_pkg::RESP_OKAY : pkh_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Configuration bytes, one per register slot
    genvar g;
    generate
        for (g = 0; g < CFG_N; g++) begin : g_cfg
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    cfg_q[g] <= pkh_pkg::CFG_RST[8*g +: 8];
                end else if (wr_en && wr_idx_q == pkh_pkg::IDX_MARK2 + 10'(g)) begin
                    cfg_q[g] <= wr_byte_q;
                end
            end
        end
    endgenerate

    // Go bit is a one-cycle start, reads back as zero
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= pkh_pkg::CTRL_RST;
            go_q   <= 1'b0;
        end else begin
            go_q <= wr_en && wr_idx_q == pkh_pkg::IDX_CTRL && wr_byte_q[pkh_pkg::CTRL_GO_BIT];
            if (wr_en && wr_idx_q == pkh_pkg::IDX_CTRL) ctrl_q <= wr_byte_q & 8'h7f;
        end
    end

    // ==========================================================
    // Field decode
    wire [2:0]  hd_raw   = ctrl_q[pkh_pkg::CTRL_HDLEN_LSB +: 3];
    wire [2:0]  hd_eff   = hd_raw > pkh_pkg::HDLEN_MAX ? pkh_pkg::HDLEN_MAX : hd_raw;
    wire        fixlen   = ctrl_q[pkh_pkg::CTRL_FIX_BIT];
    wire [1:0]  synclen  = ctrl_q[pkh_pkg::CTRL_SYNCLEN_LSB +: 2];
    wire        hdr_chk  = ctrl_q[pkh_pkg::CTRL_CHECK_BIT];
    wire [7:0]  paylen   = cfg_q[7];
    wire [31:0] sync_w   = {marker_byte3, cfg_q[0], cfg_q[1], cfg_q[2]};
    wire [31:0] hdr_w    = {cfg_q[3], cfg_q[4], cfg_q[5], cfg_q[6]};
    wire [31:0] exp_w    = {cfg_q[8], expected_header_low};

    // ==========================================================
    // Outbound frames
    pkh_tx_seq #(
        .PREAMBLE_BYTES(PREAMBLE_BYTES)
    ) u_tx (
        .mclk       (mclk),
        .rstn       (rstn),
        .start      (go_q),
        .sync_word  (sync_w),
        .header_word(hdr_w),
        .hdr_count  (hd_eff),
        .fixed_len  (fixlen),
        .sync_count (synclen),
        .pay_len    (paylen),
        .pay_data   (pay_data),
        .pay_valid  (pay_valid),
        .pay_ready  (pay_ready),
        .out_data   (tx_data),
        .out_valid  (tx_valid),
        .out_ready  (tx_ready),
        .busy       (tx_busy)
    );

    // ==========================================================
    // Inbound header check
    pkh_pkg::pkh_rx_e rx_state_q;
    logic [7:0]       rx_cnt_q;
    logic [7:0]       rx_len_q;
    logic             rx_bad_q;
    logic             acc_q;
    logic             rej_q;
    logic             last_acc_q;
    logic             last_rej_q;

    function automatic pkh_pkg::pkh_rx_e rx_skip(input pkh_pkg::pkh_rx_e s, input logic [7:0] n);
        pkh_pkg::pkh_rx_e r;
        r = s;
        if (r == pkh_pkg::RX_HDR && hd_eff == 3'h0) r = pkh_pkg::RX_LEN;
        if (r == pkh_pkg::RX_LEN && fixlen) r = pkh_pkg::RX_PAY;
        if (r == pkh_pkg::RX_PAY && n == 8'h00) r = pkh_pkg::RX_DONE;
        return r;
    endfunction

    wire [1:0] rx_sel   = 2'h3 - rx_cnt_q[1:0];
    wire       rx_take  = rx_valid && rx_state_q inside {pkh_pkg::RX_HDR, pkh_pkg::RX_LEN, pkh_pkg::RX_PAY};
    wire       rx_miss  = hdr_chk && header_check_mask[rx_sel] &&
                          rx_data != exp_w[{rx_sel, 3'h0} +: 8];
    wire       hdr_last = rx_cnt_q == {5'h0, hd_eff} - 8'h1;
    wire [7:0] rx_need  = fixlen ? paylen : rx_len_q;
    wire [7:0] rx_first = fixlen ? paylen : 8'hff;
    wire       pay_last = rx_cnt_q == rx_need - 8'h1;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rx_state_q <= pkh_pkg::RX_IDLE;
            rx_cnt_q   <= 8'h00;
            rx_len_q   <= 8'h00;
            rx_bad_q   <= 1'b0;
        end else if (rx_start) begin
            rx_state_q <= rx_skip(pkh_pkg::RX_HDR, rx_first);
            rx_cnt_q   <= 8'h00;
            rx_len_q   <= paylen;
            rx_bad_q   <= 1'b0;
        end else if (rx_state_q == pkh_pkg::RX_DONE) begin
            rx_state_q <= pkh_pkg::RX_IDLE;
        end else if (rx_take) begin
            case (rx_state_q)
                pkh_pkg::RX_HDR: begin
                    if (rx_miss) rx_bad_q <= 1'b1;
                    rx_cnt_q <= hdr_last ? 8'h00 : rx_cnt_q + 8'h1;
                    if (hdr_last) rx_state_q <= rx_skip(pkh_pkg::RX_LEN, rx_first);
                end
                pkh_pkg::RX_LEN: begin
                    rx_len_q   <= rx_data;
                    rx_state_q <= rx_skip(pkh_pkg::RX_PAY, rx_data);
                end
                default: begin
                    rx_cnt_q <= rx_cnt_q + 8'h1;
                    if (pay_last) rx_state_q <= pkh_pkg::RX_DONE;
                end
            endcase
        end
    end

    // Last result holds until the next frame begins
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            acc_q      <= 1'b0;
            rej_q      <= 1'b0;
            last_acc_q <= 1'b0;
            last_rej_q <= 1'b0;
        end else begin
            acc_q <= rx_state_q == pkh_pkg::RX_DONE && !rx_bad_q;
            rej_q <= rx_state_q == pkh_pkg::RX_DONE && rx_bad_q;
            if (rx_state_q == pkh_pkg::RX_DONE) begin
                last_acc_q <= !rx_bad_q;
                last_rej_q <= rx_bad_q;
            end else if (rx_start) begin
                last_acc_q <= 1'b0;
                last_rej_q <= 1'b0;
            end
        end
    end

    assign rx_accept = acc_q;
    assign rx_reject = rej_q;

    // ==========================================================
    // Read path
    wire [31:0] stat_w = {16'h0000, rx_len_q, 5'h00, last_rej_q, last_acc_q, tx_busy};
    wire [31:0] rd_mux = rd_cfg ? {24'h000000, cfg_q[rd_slot[3:0]]} :
                         rd_idx == pkh_pkg::IDX_CTRL ? {24'h000000, ctrl_q} :
                         rd_idx == pkh_pkg::IDX_STAT ? stat_w : 32'h00000000;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= pkh_pkg::RESP_OKAY;
        end else if (rd_go) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= mapped(rd_idx) ? pkh_pkg::RESP_OKAY : pkh_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ==========================================================
    // Checks
    logic seen_q;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) seen_q <= 1'b0;
        else seen_q <= 1'b1;
    end

    marker_write_a: assert property (@(posedge mclk) disable iff (!rstn)
        wr_en && wr_idx_q == pkh_pkg::IDX_MARK0 |=> sync_w[7:0] == $past(wr_byte_q))
        else $error("marker byte 0 write lost");
    header_write_a: assert property (@(posedge mclk) disable iff (!rstn)
        wr_en && wr_idx_q == pkh_pkg::IDX_HDR3 |=> hdr_w[31:24] == $past(wr_byte_q))
        else $error("header byte 3 write lost");
    length_read_a: assert property (@(posedge mclk) disable iff (!rstn)
        rd_go && rd_idx == pkh_pkg::IDX_LEN |=> s_axi_rvalid && s_axi_rdata == {24'h0, $past(paylen)})
        else $error("length readback wrong");
    fixed_count_a: assert property (@(posedge mclk) disable iff (!rstn)
        rx_take && !rx_start && rx_state_q == pkh_pkg::RX_PAY && fixlen && rx_cnt_q == paylen - 8'h1
        |=> rx_state_q == pkh_pkg::RX_DONE)
        else $error("fixed length payload count wrong");
    check_reject_a: assert property (@(posedge mclk) disable iff (!rstn)
        rx_state_q == pkh_pkg::RX_HDR && rx_take && !rx_start && rx_miss
        |=> rx_bad_q)
        else $error("mismatched header not flagged");
    reject_pulse_a: assert property (@(posedge mclk) disable iff (!rstn)
        rx_state_q == pkh_pkg::RX_DONE && rx_bad_q |=> rx_reject && !rx_accept)
        else $error("flagged frame not rejected");
    expect_reset_a: assert property (@(posedge mclk) disable iff (!rstn)
        !seen_q |-> cfg_q[8] == 8'h00)
        else $error("expected header byte 3 reset wrong");
    len_byte_a: assert property (@(posedge mclk) disable iff (!rstn)
        rx_state_q == pkh_pkg::RX_LEN |-> !fixlen)
        else $error("length byte taken in fixed mode");
    unmapped_a: assert property (@(posedge mclk) disable iff (!rstn)
        rd_go && !mapped(rd_idx) |=> s_axi_rresp == pkh_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read answer wrong");

    tx_frame_c: cover property (@(posedge mclk) disable iff (!rstn) go_q ##[1:300] !tx_busy);
    rx_accept_c: cover property (@(posedge mclk) disable iff (!rstn) rx_accept);
    rx_reject_c: cover property (@(posedge mclk) disable iff (!rstn) rx_reject);
    bad_addr_c: cover property (@(posedge mclk) disable iff (!rstn) s_axi_bvalid && s_axi_bresp != 2'h0);
endmodule
`default_nettype wire

// >>> dv/pkh_sink.sv
// Outbound byte stream sink that can stall on alternate cycles
`timescale 1ns/1ns
`default_nettype none
module pkh_sink (
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic slow,
    output logic      tx_ready
);
    // Slow mode drops ready every other cycle so held bytes are exercised
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) tx_ready <= 1'b0;
        else       tx_ready <= slow ? ~tx_ready : 1'b1;
    end
endmodule
`default_nettype wire

// >>> dv/packet_handler_config_tb.sv
// Self-checking bench for the packet handler configuration block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %0t got %h want %h", $time, g, e); end end
module packet_handler_config_tb;
    logic        mclk, rstn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd32;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp;
    logic [7:0]  pay_data, tx_data, rx_data;
    logic        pay_valid, pay_ready, tx_valid, tx_ready, tx_busy, slow;
    logic        rx_start, rx_valid, rx_accept, rx_reject;
    logic [7:0]  txq[$], expq[$], rxb[6];
    int          n_mismatch, checks, cyc, acc_n, rej_n, a0, r0;
    pkh_top #(.PREAMBLE_BYTES(4)) i_dut (.mclk(mclk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .marker_byte3(8'h2d),
        .expected_header_low(24'h212223), .header_check_mask(4'hf), .pay_data(pay_data), .pay_valid(pay_valid),
        .pay_ready(pay_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_busy(tx_busy),
        .rx_start(rx_start), .rx_data(rx_data), .rx_valid(rx_valid), .rx_accept(rx_accept), .rx_reject(rx_reject));
    pkh_sink i_sink (.mclk(mclk), .rstn(rstn), .slow(slow), .tx_ready(tx_ready));
    initial begin
        mclk = 0;
        forever #25 mclk = ~mclk;
    end
    // Observe at the falling edge, where every registered output has settled
    always @(negedge mclk) begin
        if (tx_valid && tx_ready) txq.push_back(tx_data);
        if (rx_accept) acc_n++;
        if (rx_reject) rej_n++;
    end
    // Payload source steps only on an accepted byte
    always @(posedge mclk) begin
        if (!rstn) pay_data <= 8'h60;
        else if (pay_valid && pay_ready) pay_data <= pay_data + 8'h01;
        cyc++;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic ta, tw, tk;
        awaddr <= {idx, 2'b00}; wdata <= {24'h0, d}; awvalid <= 1; wvalid <= 1; bready <= 1;
        tk = 0;
        while (!tk) begin
            @(negedge mclk); ta = awvalid && awready; tw = wvalid && wready; tk = bvalid && bready; resp = bresp;
            @(posedge mclk); if (ta) awvalid <= 0; if (tw) wvalid <= 0;
        end
        // Ready stays up; lowering it here would clash with the next call raising it
    endtask
    task automatic rd(input logic [9:0] idx);
        logic ta, tk;
        araddr <= {idx, 2'b00}; arvalid <= 1; rready <= 1;
        tk = 0;
        while (!tk) begin
            @(negedge mclk); ta = arvalid && arready; tk = rvalid && rready; resp = rresp; rd32 = rdata;
            @(posedge mclk); if (ta) arvalid <= 0;
        end
    endtask
    task automatic txrun(input logic [7:0] ctrl);
        int base;
        base = txq.size();
        wr(pkh_pkg::IDX_CTRL, ctrl);
        repeat (4) @(posedge mclk);
        do @(negedge mclk); while (tx_busy !== 1'b0);
        @(posedge mclk);
        `CHK(txq.size() - base, expq.size())
        foreach (expq[i]) `CHK(txq[base + i], expq[i])
    endtask
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, rx_start, rx_valid} = '0;
        {awaddr, araddr, wdata, rx_data} = '0;
        rstn = 0; wstrb = 4'hf; pay_valid = 1; slow = 1;
        repeat (20) @(posedge mclk);
        rstn <= 1;
        @(posedge mclk);
        fork
            begin
                for (int i = 0; i < 9; i++) begin
                    rd(pkh_pkg::IDX_MARK2 + 10'(i));
                    `CHK(rd32, (i == 0) ? 32'h000000d4 : 32'h0)
                end
                $display("test reset_values done");
                for (int i = 0; i < 9; i++) wr(pkh_pkg::IDX_MARK2 + 10'(i), 8'h10 + 8'(i));
                for (int i = 0; i < 9; i++) begin
                    rd(pkh_pkg::IDX_MARK2 + 10'(i));
                    `CHK(rd32, 32'h10 + 32'(i))
                end
                wr(10'h000, 8'h5a); `CHK(resp, pkh_pkg::RESP_SLVERR)
                rd(10'h000); `CHK(rd32, 32'h0)
                $display("test registers done");
                wr(pkh_pkg::IDX_LEN, 8'h02);
                expq = {8'haa, 8'haa, 8'haa, 8'haa, 8'h2d, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16,
                        8'h02, 8'h60, 8'h61};
                txrun(8'hb4);
                slow <= 0;
                wr(pkh_pkg::IDX_LEN, 8'h00);
                expq = {8'haa, 8'haa, 8'haa, 8'haa, 8'h2d};
                txrun(8'h88);
                $display("test frames done");
                wr(pkh_pkg::IDX_CTRL, 8'h4c);
                wr(pkh_pkg::IDX_LEN, 8'h02);
                for (int k = 0; k < 2; k++) begin
                    a0 = acc_n; r0 = rej_n;
                    rxb = '{8'h18 + 8'(k), 8'h21, 8'h22, 8'h23, 8'h77, 8'h88};
                    @(posedge mclk); rx_start <= 1;
                    foreach (rxb[j]) begin
                        @(posedge mclk); rx_start <= 0; rx_valid <= 1; rx_data <= rxb[j];
                    end
                    @(posedge mclk); rx_valid <= 0;
                    repeat (4) @(posedge mclk);
                    `CHK(acc_n - a0, (k == 0))
                    `CHK(rej_n - r0, (k == 1))
                end
                $display("test receive_check done");
            end
            begin
                // Ceiling far above the few hundred cycles the tests need
                wait (cyc >= 20000);
                n_mismatch++;
                $display("BAD %0t timeout", $time);
            end
        join_any
        tally_and_finish();
    end
endmodule
`default_nettype wire
